// [hw/srd_decode.sv]
// Special register decode, access and privilege checking for the core
// How it works
// [RULE1] Time-base field decoded with halves exchanged
// [RULE2] Time-base 268/269 read unprivileged, read-only
// [RULE3] Time-base writes only privileged at 284/285
// [RULE4] Scratch four-seven privileged read/write at 276-279
// [RULE5] User attribute register 956 privileged, resets zero
// [RULE6] Device control moves privileged, routed internal/external
// [RULE7] Special register numbers decoded in split form
// [RULE8] User access to privileged register raises exception
`timescale 1ns/1ps
`default_nettype none

module srd_decode (
    input  wire logic                clk,          // Core clock, 200 MHz
    input  wire logic                rst_n,        // Asynchronous reset, active low
    input  wire logic                reqValid,     // Instruction offered
    input  wire srd_pkg::srd_req_type req,         // Instruction fields
    output logic                     reqReady,     // Instruction can be taken
    output logic                     respValid,    // Instruction finished, one cycle
    output logic [31:0]              respData,     // Read result
    output logic                     privFault,    // Privileged-instruction exception
    output logic                     badReg,       // Unmapped or wrong-direction access
    output logic                     dcrIntValid,  // Request to wrapper registers
    output logic                     dcrExtValid,  // Request to external control bus
    output srd_pkg::srd_dcr_type     dcrReq,       // Shared request fields
    input  wire logic                dcrIntAck,    // Wrapper finished
    input  wire logic [31:0]         dcrIntRdata,  // Wrapper read data
    input  wire logic                dcrExtAck,    // External bus finished
    input  wire logic [31:0]         dcrExtRdata,  // External read data
    output logic [63:0]              timeBase      // Running time base
);

    // Device control handshake states, Gray along the path
    typedef enum logic [1:0] {
        SRD_IDLE = 2'b00,  // Ready for an instruction
        SRD_WAIT = 2'b01   // Waiting for the target's acknowledge
    } srd_state_type;

    // Reset released through two flip-flops
    logic                          rstPipe;      // First reset stage
    logic                          rstSync_n;    // Reset used by the design
    srd_state_type                 state;        // Handshake state
    logic [31:0]                   store [srd_pkg::SRD_NSTORE]; // Stored registers
    logic [9:0]                    num;          // Decoded register number
    logic                          accept;       // Instruction taken this cycle
    logic                          storeHit;     // Number names a stored register
    logic [srd_pkg::SRD_IDXW-1:0]  storeIdx;     // Index of that register
    logic                          isDcr;        // Device control class
    logic                          dcrIsInt;     // Targets wrapper window
    logic                          opRead;       // Move from class
    logic                          userAlias;    // Unprivileged scratch read alias
    logic                          tbRead;       // Time-base read numbers
    logic                          tbWrite;      // Time-base write numbers
    logic                          readable;     // Number readable by this class
    logic                          writable;     // Number writable by this class
    logic                          needPriv;     // Access needs supervisor state
    logic                          legal;        // Access is mapped and allowed
    logic [31:0]                   readValue;    // Selected read data
    logic                          wrStore;      // Stored register write strobe
    logic                          dcrAck;       // Acknowledge of current target
    logic                          pendInt;      // Current transfer is internal

    // Split field back to a number: halves exchanged
    function automatic logic [9:0] srd_unsplit(input logic [9:0] f);
        srd_unsplit = {f[srd_pkg::SRD_HALF_WIDTH-1:0],
                       f[9:srd_pkg::SRD_SPLIT_HI_LSB]};
    endfunction : srd_unsplit

    // Search of the stored-register table, hit flag above the index
    function automatic logic [srd_pkg::SRD_IDXW:0] srd_lookup(input logic [9:0] n);
        srd_lookup = '0;
        for (int i = 0; i < srd_pkg::SRD_NSTORE; i++) begin
            if (srd_pkg::SRD_STORE_NUM[i] == n) begin
                srd_lookup = {1'b1, i[srd_pkg::SRD_IDXW-1:0]};
            end
        end
    endfunction : srd_lookup

    // Reset synchroniser: asserts at once, releases after two edges
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rstPipe   <= 1'b0;
            rstSync_n <= 1'b0;
        end else begin
            rstPipe   <= 1'b1;
            rstSync_n <= rstPipe;
        end
    end

    // Every class uses the same exchanged-halves split form
    assign num    = srd_unsplit(req.splitField);  // RULE1 RULE7
    assign accept = reqValid && reqReady;
    assign reqReady = (state == SRD_IDLE);
    assign isDcr  = (req.op == srd_pkg::SRD_OP_MFDCR) || (req.op == srd_pkg::SRD_OP_MTDCR);
    assign opRead = (req.op == srd_pkg::SRD_OP_MFSPR) || (req.op == srd_pkg::SRD_OP_MFTB);
    assign {storeHit, storeIdx} = srd_lookup(num);

    // Unprivileged read-only copies of scratch four to seven
    assign userAlias = (num[9:2] == srd_pkg::SRD_SCRATCH_USER4[9:2]);
    assign tbRead    = (num == srd_pkg::SRD_TB_LOW_READ) ||
                       (num == srd_pkg::SRD_TB_HIGH_READ);
    assign tbWrite   = (num == srd_pkg::SRD_TB_LOW_WRITE) ||
                       (num == srd_pkg::SRD_TB_HIGH_WRITE);

    // Direction map: time-base reads only by the time-base class
    always_comb begin
        readable = 1'b0;
        writable = 1'b0;
        case (req.op)
            srd_pkg::SRD_OP_MFTB: begin
                readable = tbRead;  // RULE2
            end
            srd_pkg::SRD_OP_MFSPR: begin
                readable = storeHit || userAlias ||
                           (num == srd_pkg::SRD_CORE_VERSION) ||
                           (num == srd_pkg::SRD_ICACHE_DEBUG);
            end
            srd_pkg::SRD_OP_MTSPR: begin
                writable = storeHit || tbWrite;  // RULE3
            end
            default: begin
                readable = 1'b0;
                writable = 1'b0;
            end
        endcase
    end

    // Only the time-base reads and the scratch aliases are open to user code
    assign needPriv = isDcr ||                                      // RULE6
                      !((req.op == srd_pkg::SRD_OP_MFTB) ||
                        ((req.op == srd_pkg::SRD_OP_MFSPR) && userAlias)); // RULE2 RULE4
    assign legal = isDcr || readable || writable;

    // Read mux over every readable source
    always_comb begin
        readValue = 32'h0000_0000;
        if (req.op == srd_pkg::SRD_OP_MFTB) begin
            readValue = (num == srd_pkg::SRD_TB_HIGH_READ) ? timeBase[63:32]
                                                           : timeBase[31:0]; // RULE2
        end else if (storeHit) begin
            readValue = store[storeIdx];  // RULE4 RULE5
        end else if (userAlias) begin
            readValue = store[storeIdx] ;
            for (int i = 0; i < 4; i++) begin
                if (num[1:0] == i[1:0]) begin
                    readValue = store[2 + i];
                end
            end
        end else if (num == srd_pkg::SRD_CORE_VERSION) begin
            readValue = srd_pkg::SRD_VERSION_VALUE;
        end else begin
            readValue = 32'h0000_0000;  // Cache debug data not modelled here
        end
    end

    // Stored register written only by a legal supervisor move-to
    assign wrStore = accept && (req.op == srd_pkg::SRD_OP_MTSPR) && storeHit &&
                     !req.userMode;  // RULE8

    // Stored registers; timer status clears the bits written as one
    generate
        for (genvar g = 0; g < srd_pkg::SRD_NSTORE; g++) begin : gStore
            always_ff @(posedge clk or negedge rstSync_n) begin
                if (!rstSync_n) begin
                    store[g] <= srd_pkg::SRD_STORE_RST[g];  // RULE5
                end else if (wrStore && (storeIdx == g[srd_pkg::SRD_IDXW-1:0])) begin
                    if (srd_pkg::SRD_STORE_NUM[g] == srd_pkg::SRD_TIMER_STATUS) begin
                        store[g] <= store[g] & ~req.wdata;
                    end else begin
                        store[g] <= req.wdata;  // RULE4 RULE5
                    end
                end
            end
        end
    endgenerate

    // Free-running time base, halves loaded through the write aliases
    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            timeBase <= 64'h0000_0000_0000_0000;
        end else if (accept && (req.op == srd_pkg::SRD_OP_MTSPR) && tbWrite &&
                     !req.userMode) begin
            if (num == srd_pkg::SRD_TB_HIGH_WRITE) begin
                timeBase <= {req.wdata, timeBase[31:0]};  // RULE3
            end else begin
                timeBase <= {timeBase[63:32], req.wdata};  // RULE3
            end
        end else begin
            timeBase <= timeBase + 64'h0000_0000_0000_0001;
        end
    end

    // Number inside the wrapper window picks wrapper, any other the external target
    assign dcrIsInt = (num >= srd_pkg::SRD_DCR_INT_BASE) &&
                      (num < srd_pkg::SRD_DCR_INT_BASE + srd_pkg::SRD_DCR_INT_SIZE);
    assign dcrAck   = pendInt ? dcrIntAck : dcrExtAck;

    // Device control handshake: hold the request until acknowledged
    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            state       <= SRD_IDLE;
            dcrIntValid <= 1'b0;
            dcrExtValid <= 1'b0;
            pendInt     <= 1'b0;
            dcrReq      <= '0;
        end else begin
            case (state)
                SRD_IDLE: begin
                    if (accept && isDcr && !req.userMode) begin
                        state       <= SRD_WAIT;  // RULE6
                        dcrIntValid <= dcrIsInt;
                        dcrExtValid <= !dcrIsInt;
                        pendInt     <= dcrIsInt;
                        dcrReq      <= '{write: (req.op == srd_pkg::SRD_OP_MTDCR),
                                         addr: num, wdata: req.wdata};
                    end
                end
                SRD_WAIT: begin
                    if (dcrAck) begin
                        state       <= SRD_IDLE;
                        dcrIntValid <= 1'b0;
                        dcrExtValid <= 1'b0;
                    end
                end
                default: begin
                    state <= SRD_IDLE;
                end
            endcase
        end
    end

    // Completion and exception flags one cycle each, read data held until the next answer
    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            respValid <= 1'b0;
            respData  <= 32'h0000_0000;
            privFault <= 1'b0;
            badReg    <= 1'b0;
        end else begin
            respValid <= 1'b0;
            privFault <= 1'b0;
            badReg    <= 1'b0;
            if ((state == SRD_WAIT) && dcrAck) begin
                respValid <= 1'b1;
                respData  <= dcrReq.write ? 32'h0000_0000
                           : (pendInt ? dcrIntRdata : dcrExtRdata);
            end else if (accept && !(isDcr && !req.userMode)) begin
                // Privilege is checked before the map, so user code learns nothing
                respValid <= 1'b1;
                respData  <= 32'h0000_0000;
                if (req.userMode && needPriv) begin
                    privFault <= 1'b1;  // RULE8
                end else if (!legal) begin
                    badReg <= 1'b1;
                end else if (opRead) begin
                    respData <= readValue;
                end
            end
        end
    end

    // Checks of the documented behaviour
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstSync_n);

    a_split_tb_low: assert property ( // RULE1
        accept && req.op == srd_pkg::SRD_OP_MFTB && req.splitField == 10'h188 &&
        !req.userMode |=> respValid && respData == $past(timeBase[31:0]))
        else $error("time-base low read by split field failed");

    a_tb_user_read: assert property ( // RULE2
        accept && req.op == srd_pkg::SRD_OP_MFTB && tbRead && req.userMode
        |=> respValid && !privFault && !badReg)
        else $error("user time-base read was refused");

    a_tb_write_priv: assert property ( // RULE3
        accept && req.op == srd_pkg::SRD_OP_MTSPR && tbWrite && req.userMode
        |=> privFault && timeBase == $past(timeBase) + 64'h0000_0000_0000_0001)
        else $error("user time-base write not refused");

    a_tb_high_load: assert property ( // RULE3
        accept && req.op == srd_pkg::SRD_OP_MTSPR && !req.userMode &&
        num == srd_pkg::SRD_TB_HIGH_WRITE |=> timeBase[63:32] == $past(req.wdata))
        else $error("time-base high write not loaded");

    a_scratch_back: assert property ( // RULE4
        accept && req.op == srd_pkg::SRD_OP_MTSPR && !req.userMode &&
        num == srd_pkg::SRD_SCRATCH_PRIV4 |=> store[2] == $past(req.wdata))
        else $error("scratch four write lost");

    a_user_attr_rst: assert property ( // RULE5
        $rose(rstSync_n) |-> store[srd_pkg::SRD_IDX_USER_ATTR] == 32'h0000_0000)
        else $error("user attribute register not zero after reset");

    a_dcr_routed: assert property ( // RULE6
        accept && isDcr && !req.userMode
        |=> (dcrIntValid ^ dcrExtValid) && dcrReq.addr == $past(num))
        else $error("device control move not routed");

    a_dcr_user: assert property ( // RULE6
        accept && isDcr && req.userMode |=> privFault && !dcrIntValid && !dcrExtValid)
        else $error("user device control move not refused");

    a_priv_fault: assert property ( // RULE8
        accept && req.userMode && needPriv && !isDcr
        |=> privFault && respValid ##1 !privFault)
        else $error("privileged access from user mode missed");

    // Split form of the user attribute number must land on its own word
    a_split_decode: assert property ( // RULE7
        accept && req.splitField == 10'h39d |-> storeHit &&
        storeIdx == srd_pkg::SRD_IDX_USER_ATTR)
        else $error("split field decoded wrongly");

    // Write-only time-base aliases never answer a read
    a_tb_alias_wo: assert property ( // RULE3
        accept && req.op == srd_pkg::SRD_OP_MFSPR && tbWrite && !req.userMode
        |=> badReg && respData == 32'h0000_0000)
        else $error("time-base write alias answered a read");

    // User code can neither read nor change the attribute word
    a_attr_priv: assert property ( // RULE5
        accept && req.userMode && storeHit && storeIdx == srd_pkg::SRD_IDX_USER_ATTR
        |=> privFault && $stable(store[srd_pkg::SRD_IDX_USER_ATTR]))
        else $error("user access to attribute word not refused");

    // Target sees one steady request until it acknowledges
    a_dcr_hold: assert property ( // RULE6
        (dcrIntValid || dcrExtValid) && !dcrAck
        |=> (dcrIntValid || dcrExtValid) && $stable(dcrReq))
        else $error("device control request dropped before acknowledge");

    c_dcr_done: cover property (accept && isDcr && !req.userMode ##[1:20] respValid);
    c_user_fault: cover property (accept && req.userMode && needPriv ##1 privFault);
    c_tb_read: cover property (accept && req.op == srd_pkg::SRD_OP_MFTB ##1 respValid);
    c_alias_read: cover property (accept && userAlias && req.userMode ##1 respValid);
    c_bad_number: cover property (accept && !legal && !req.userMode ##1 badReg);

endmodule : srd_decode

`default_nettype wire

// [hw/srd_pkg.sv]
// Shared constants and types for the special register decode block
`default_nettype none

package srd_pkg;

    // Instruction classes that reach this block
    typedef enum logic [2:0] {
        SRD_OP_MFSPR = 3'h0,  // Move from special register
        SRD_OP_MTSPR = 3'h1,  // Move to special register
        SRD_OP_MFTB  = 3'h2,  // Move from time base
        SRD_OP_MFDCR = 3'h3,  // Move from device control register
        SRD_OP_MTDCR = 3'h4   // Move to device control register
    } srd_op_type;

    // One issued register-move instruction
    typedef struct packed {
        srd_op_type  op;         // Instruction class
        logic [9:0]  splitField; // Register number in split-field form
        logic        userMode;   // Issued from problem state
        logic [31:0] wdata;      // Source operand for moves to
    } srd_req_type;

    // Device control transfer toward the wrapper or the external bus
    typedef struct packed {
        logic        write;      // Move to, else move from
        logic [9:0]  addr;       // Decoded register number
        logic [31:0] wdata;      // Write data
    } srd_dcr_type;

    // Register numbers with their own behaviour
    localparam logic [9:0] SRD_TB_LOW_READ   = 10'h10c;
    localparam logic [9:0] SRD_TB_HIGH_READ  = 10'h10d;
    localparam logic [9:0] SRD_TB_LOW_WRITE  = 10'h11c;
    localparam logic [9:0] SRD_TB_HIGH_WRITE = 10'h11d;
    localparam logic [9:0] SRD_CORE_VERSION  = 10'h11f;
    localparam logic [9:0] SRD_ICACHE_DEBUG  = 10'h3d3;
    localparam logic [9:0] SRD_SCRATCH_USER4 = 10'h104;  // Unprivileged read alias base
    localparam logic [9:0] SRD_SCRATCH_PRIV4 = 10'h114;  // Privileged scratch four
    localparam logic [9:0] SRD_TIMER_STATUS  = 10'h3d8;

    // Field positions of the split form: low half of number sits high
    localparam int SRD_SPLIT_HI_LSB = 5;
    localparam int SRD_HALF_WIDTH   = 5;

    // Arbitrary core version value, names no real part
    localparam logic [31:0] SRD_VERSION_VALUE = 32'h0000_0100;

    // Device control window kept inside the wrapper
    localparam logic [9:0] SRD_DCR_INT_BASE = 10'h000;
    localparam logic [9:0] SRD_DCR_INT_SIZE = 10'h010;

    // Stored registers, one flip-flop word each
    localparam int SRD_NSTORE = 30;
    localparam int SRD_IDXW   = 5;

    // Number of each stored register, by index
    localparam logic [9:0] SRD_STORE_NUM [SRD_NSTORE] = '{
        10'h01a, 10'h01b, 10'h114, 10'h115, 10'h116, 10'h117,
        10'h3b3, 10'h3b4, 10'h3b5, 10'h3b6, 10'h3b7, 10'h3b9,
        10'h3ba, 10'h3bb, 10'h3bc, 10'h3bd, 10'h3d4, 10'h3d5,
        10'h3d6, 10'h3d8, 10'h3da, 10'h3db, 10'h3de, 10'h3df,
        10'h3f4, 10'h3f5, 10'h3f6, 10'h3f7, 10'h3fa, 10'h3fb
    };

    // Reset value of each stored register, by index
    localparam logic [31:0] SRD_STORE_RST [SRD_NSTORE] = '{
        32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
        32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
        32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'hffff_ffff,
        32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
        32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
        32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
        32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
        32'h0000_0000, 32'h0000_0000
    };

    // Index of the user-defined storage attribute register
    localparam logic [SRD_IDXW-1:0] SRD_IDX_USER_ATTR = 5'h0e;

endpackage : srd_pkg

`default_nettype wire

// [tb/srd_testbench.sv]
// Self-checking bench for the special register decode block
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin fails++; $display("[FAIL] %s expected %h seen %h", nm, e, g); end end

module testbench;
    logic                 clk;         // Core clock, 5 ns period
    logic                 rst_n;       // Reset, active low
    logic                 reqValid;    // Instruction offered
    srd_pkg::srd_req_type req;         // Instruction fields
    logic                 reqReady;    // Block can take an instruction
    logic                 respValid;   // Answer pulse
    logic [31:0]          respData;    // Answer data
    logic                 privFault;   // Privilege exception pulse
    logic                 badReg;      // Unmapped or wrong direction pulse
    logic                 dcrIntValid; // Wrapper request
    logic                 dcrExtValid; // External bus request
    srd_pkg::srd_dcr_type dcrReq;      // Request fields
    logic                 dcrIntAck;   // Wrapper done
    logic                 dcrExtAck;   // External bus done
    logic [31:0]          dcrRdata;    // One read value feeds both targets
    logic [63:0]          timeBase;    // Running time base
    int                   fails;       // Mismatches
    int                   checked;     // Comparisons
    logic [31:0]          rData;       // Captured answer
    logic                 rFault;
    logic                 rBad;
    logic [1:0]           rDcr;        // Which target saw a request
    srd_pkg::srd_dcr_type rDcrReq;     // Request fields as the target saw them
    logic [9:0]           addrs [4];   // Window edges of the control space
    // Short names for the instruction classes
    localparam srd_pkg::srd_op_type MF = srd_pkg::SRD_OP_MFSPR;
    localparam srd_pkg::srd_op_type MT = srd_pkg::SRD_OP_MTSPR;
    localparam srd_pkg::srd_op_type TB = srd_pkg::SRD_OP_MFTB;

    srd_decode u_srd_decode (
        .clk(clk), .rst_n(rst_n), .reqValid(reqValid), .req(req), .reqReady(reqReady),
        .respValid(respValid), .respData(respData), .privFault(privFault), .badReg(badReg),
        .dcrIntValid(dcrIntValid), .dcrExtValid(dcrExtValid), .dcrReq(dcrReq),
        .dcrIntAck(dcrIntAck), .dcrIntRdata(dcrRdata), .dcrExtAck(dcrExtAck),
        .dcrExtRdata(dcrRdata), .timeBase(timeBase)
    );

    // Free-running clock
    initial clk = 1'b0;
    always #2.5 clk = ~clk;

    // Verdict and end of run, the only exit
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : stop_test

    // Reset held two cycles, first request on the fourth edge after release
    task automatic do_reset();
        rst_n = 1'b0;
        repeat (2) @(posedge clk);
        #1 rst_n = 1'b1;
        repeat (3) @(posedge clk);
        #1;
    endtask : do_reset

    // One instruction: offer until taken, then wait for its answer
    task automatic issue(input srd_pkg::srd_op_type op, input logic [9:0] num,
                         input logic usr, input logic [31:0] wd);
        int n;
        int w;
        begin
            req = '{op: op, splitField: {num[4:0], num[9:5]}, userMode: usr, wdata: wd};
            reqValid = 1'b1;
            rDcr = 2'b00;
            n = 0;
            w = 0;
            while (reqReady !== 1'b1 && n < 20) begin
                @(posedge clk); #1; n++;
            end
            @(posedge clk); #1;
            reqValid = 1'b0;
            // Target answers slowly, on its third cycle of request
            while (respValid !== 1'b1 && n < 40) begin
                if (dcrIntValid === 1'b1 || dcrExtValid === 1'b1) begin
                    rDcr = {dcrIntValid, dcrExtValid};
                    rDcrReq = dcrReq;
                    w++;
                end
                dcrIntAck = dcrIntValid & (w > 2);
                dcrExtAck = dcrExtValid & (w > 2);
                @(posedge clk); #1; n++;
            end
            dcrIntAck = 1'b0;
            dcrExtAck = 1'b0;
            if (n >= 40) begin
                fails++;
                $display("[FAIL] answer wait expected 1 seen 0");
                stop_test();
            end
            rData = respData;
            rFault = privFault;
            rBad = badReg;
            // Let an edge pass so the next offer does not reuse this time step
            @(posedge clk); #1;
        end
    endtask : issue

    // Compare the captured answer with its expectation
    task automatic check(input string nm, input logic [31:0] d, input int f, input int b);
        `CHK({nm, " data"}, d, rData)
        `CHK({nm, " fault"}, f, rFault)
        `CHK({nm, " bad"}, b, rBad)
    endtask : check

    initial begin
        fails = 0; checked = 0; reqValid = 1'b0; req = '0;
        dcrIntAck = 1'b0; dcrExtAck = 1'b0; dcrRdata = '0;
        addrs = '{10'h000, 10'h00f, 10'h010, 10'h3ff};
        do_reset();
        // Reset values and the read-only version word
        issue(MF, 10'h3bc, 1'b0, '0); check("attr reset", '0, 0, 0);
        issue(MF, 10'h3b9, 1'b0, '0); check("guarded reset", 32'hffff_ffff, 0, 0);
        issue(MF, 10'h11f, 1'b0, '0); check("version", srd_pkg::SRD_VERSION_VALUE, 0, 0);
        issue(MT, 10'h11f, 1'b0, 32'h1); check("version write", '0, 0, 1);
        $display("test reset_values done");
        // Scratch words: privileged view writes, user alias only reads
        for (int i = 0; i < 4; i++) begin
            issue(MT, 10'h114 + 10'(i), 1'b0, 32'ha5a5_0000 + i); check("scr wr", '0, 0, 0);
        end
        for (int i = 0; i < 4; i++) begin
            issue(MT, 10'h114 + 10'(i), 1'b1, 32'h0); check("scr user wr", '0, 1, 0);
            issue(MF, 10'h114 + 10'(i), 1'b0, '0); check("scr rd", 32'ha5a5_0000 + i, 0, 0);
            issue(MF, 10'h104 + 10'(i), 1'b1, '0); check("scr alias", 32'ha5a5_0000 + i, 0, 0);
        end
        $display("test scratch done");
        // User attribute word: privilege, read back, cleared by reset
        issue(MT, 10'h3bc, 1'b0, 32'hdead_beef); check("attr wr", '0, 0, 0);
        issue(MT, 10'h3bc, 1'b1, 32'h0); check("attr user wr", '0, 1, 0);
        issue(MF, 10'h3bc, 1'b1, '0); check("attr user rd", '0, 1, 0);
        issue(MF, 10'h3bc, 1'b0, '0); check("attr rd", 32'hdead_beef, 0, 0);
        do_reset();
        issue(MF, 10'h3bc, 1'b0, '0); check("attr rd after reset", '0, 0, 0);
        $display("test user_attr done");
        // Time base: privileged write aliases, unprivileged read view
        issue(MT, 10'h11c, 1'b0, 32'h0); check("tb low wr", '0, 0, 0);
        issue(MT, 10'h11d, 1'b0, 32'h1234_5678); check("tb high wr", '0, 0, 0);
        issue(MT, 10'h11d, 1'b1, 32'h0); check("tb user wr", '0, 1, 0);
        issue(TB, 10'h10d, 1'b1, '0); check("tb high rd", 32'h1234_5678, 0, 0);
        `CHK("tb port high", 32'h1234_5678, timeBase[63:32])
        issue(TB, 10'h10c, 1'b1, '0);
        `CHK("tb low small", 1'b1, (rData < 32'd40 && rFault === 1'b0))
        issue(TB, 10'h10c, 1'b0, '0);
        `CHK("tb low sup", 1'b1, (rData < 32'd40 && rBad === 1'b0))
        issue(MF, 10'h11c, 1'b0, '0); check("tb write alias rd", '0, 0, 1);
        issue(TB, 10'h11c, 1'b0, '0); check("tb bad number", '0, 0, 1);
        issue(MT, 10'h10c, 1'b0, 32'h1); check("tb read view wr", '0, 0, 1);
        $display("test time_base done");
        // Device control: privileged only, routed by window
        foreach (addrs[i]) begin
            dcrRdata = 32'h5a00_0000 | 32'(addrs[i]);
            issue(srd_pkg::SRD_OP_MFDCR, addrs[i], 1'b0, '0);
            check("dcr rd", dcrRdata, 0, 0);
            `CHK("dcr target", (addrs[i] < 10'h010) ? 2'b10 : 2'b01, rDcr)
            `CHK("dcr addr", addrs[i], rDcrReq.addr)
            issue(srd_pkg::SRD_OP_MTDCR, addrs[i], 1'b0, 32'h0000_00c3);
            `CHK("dcr wr fields", {1'b1, addrs[i], 32'h0000_00c3}, rDcrReq)
            issue(srd_pkg::SRD_OP_MTDCR, addrs[i], 1'b1, 32'h1); check("dcr user", '0, 1, 0);
            `CHK("dcr user none", 2'b00, rDcr)
        end
        $display("test device_control done");
        stop_test();
    end

endmodule : testbench

`default_nettype wire
